/* amd_decoder.sv */
// Purpose: Effective-address generator for the operand addressing modes.
// Assumes: Memory answers a byte read in the cycle after mem_rd_o (rd_data_i).
// Notes: Prefix byte is presented on prefix_i beside start_i; length excludes it.
`default_nettype none
module amd_decoder (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] prefix_i,
  input wire amd_pkg::amd_mode_t base_mode_i,
  input wire logic rmw_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] y_i,
  input wire logic [7:0] rd_data_i,
  output logic busy_o,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  output amd_pkg::amd_rsp_t rsp_o
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Unsigned index add, wraps at 16 bits
  function automatic logic [15:0] idx_add(input logic [15:0] base, input logic [7:0] idx);
    logic [16:0] s;
    s = {1'b0, base} + {9'h000, idx};
    return s[15:0];
  endfunction

  function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction

  // ----------------------------------------------------------------
  // Prefix handling
  // ----------------------------------------------------------------
  amd_pkg::amd_mode_t eff_mode;
  logic eff_y;
  always_comb begin
    eff_mode = base_mode_i;
    eff_y = 1'b0;
    if (prefix_i == amd_pkg::PFX_Y) begin
      eff_y = 1'b1;
    end else if (prefix_i == amd_pkg::PFX_IND || prefix_i == amd_pkg::PFX_IND_Y) begin
      eff_y = (prefix_i == amd_pkg::PFX_IND_Y);
      case (base_mode_i)
        amd_pkg::AM_DIR_SHORT: eff_mode = amd_pkg::AM_IND_SHORT;
        amd_pkg::AM_DIR_LONG: eff_mode = amd_pkg::AM_IND_LONG;
        amd_pkg::AM_IDX_SHORT: eff_mode = amd_pkg::AM_INDIDX_SHORT;
        amd_pkg::AM_IDX_LONG: eff_mode = amd_pkg::AM_INDIDX_LONG;
        amd_pkg::AM_REL_DIR: eff_mode = amd_pkg::AM_REL_IND;
        amd_pkg::AM_BIT_DIR: eff_mode = amd_pkg::AM_BIT_IND;
        amd_pkg::AM_BIT_DIR_REL: eff_mode = amd_pkg::AM_BIT_IND_REL;
        default: eff_mode = base_mode_i;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_B1, ST_B2, ST_B3, ST_P1, ST_P2, ST_DONE
  } amd_state_t;

  amd_state_t st_q, st_d;
  amd_pkg::amd_mode_t mode_q, mode_d;
  logic use_y_q, use_y_d;
  logic rmw_q, rmw_d;
  logic [15:0] fpc_q, fpc_d;
  logic [7:0] b1_q, b1_d;
  logic [7:0] b2_q, b2_d;
  logic [7:0] p1_q, p1_d;
  logic [2:0] len_q, len_d;
  amd_pkg::amd_rsp_t rsp_q, rsp_d;
  logic [7:0] idx;
  logic [15:0] ptr16;

  assign idx = use_y_q ? y_i : x_i;

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    use_y_d = use_y_q;
    rmw_d = rmw_q;
    fpc_d = fpc_q;
    b1_d = b1_q;
    b2_d = b2_q;
    p1_d = p1_q;
    len_d = len_q;
    rsp_d = rsp_q;
    rsp_d.valid = 1'b0;
    mem_rd_o = 1'b0;
    mem_addr_o = 16'h0000;
    ptr16 = {p1_q, rd_data_i};
    case (st_q)
      ST_IDLE: begin
        if (start_i) begin
          mode_d = eff_mode;
          use_y_d = eff_y;
          rmw_d = rmw_i;
          fpc_d = pc_i + 16'h0001;
          len_d = 3'h1;
          // Inherent and no-offset indexed need no operand fetch
          if (eff_mode == amd_pkg::AM_INHERENT) begin
            rsp_d = '0;
            rsp_d.valid = 1'b1;
            rsp_d.length = 3'h1;
          end else if (eff_mode == amd_pkg::AM_IDX_NONE) begin
            rsp_d = '0;
            rsp_d.valid = 1'b1;
            rsp_d.length = 3'h1;
            rsp_d.addr = {8'h00, eff_y ? y_i : x_i};
          end else begin
            st_d = ST_B1;
          end
        end
      end
      ST_B1: begin
        mem_rd_o = 1'b1;
        mem_addr_o = fpc_q;
        fpc_d = fpc_q + 16'h0001;
        len_d = len_q + 3'h1;
        st_d = ST_P1;
        case (mode_q)
          amd_pkg::AM_DIR_LONG, amd_pkg::AM_IDX_LONG, amd_pkg::AM_BIT_DIR_REL,
          amd_pkg::AM_BIT_IND_REL: st_d = ST_B2;
          default: st_d = ST_P1;
        endcase
      end
      ST_B2: begin
        b1_d = rd_data_i;
        mem_rd_o = 1'b1;
        if (mode_q == amd_pkg::AM_BIT_IND_REL) begin
          // Pointer read first, offset byte follows, so one extra cycle
          mem_addr_o = {8'h00, rd_data_i};
          st_d = ST_B3;
        end else begin
          mem_addr_o = fpc_q;
          fpc_d = fpc_q + 16'h0001;
          len_d = len_q + 3'h1;
          st_d = ST_DONE;
        end
      end
      ST_B3: begin
        b2_d = rd_data_i;
        mem_rd_o = 1'b1;
        mem_addr_o = fpc_q;
        fpc_d = fpc_q + 16'h0001;
        len_d = len_q + 3'h1;
        st_d = ST_DONE;
      end
      ST_P1: begin
        b1_d = rd_data_i;
        st_d = ST_DONE;
        case (mode_q)
          amd_pkg::AM_IND_SHORT, amd_pkg::AM_INDIDX_SHORT, amd_pkg::AM_REL_IND,
          amd_pkg::AM_BIT_IND: begin
            mem_rd_o = 1'b1;
            mem_addr_o = {8'h00, rd_data_i};
          end
          amd_pkg::AM_IND_LONG, amd_pkg::AM_INDIDX_LONG: begin
            mem_rd_o = 1'b1;
            mem_addr_o = {8'h00, rd_data_i};
            st_d = ST_P2;
          end
          default: st_d = ST_DONE;
        endcase
      end
      ST_P2: begin
        p1_d = rd_data_i;
        mem_rd_o = 1'b1;
        mem_addr_o = {8'h00, b1_q + 8'h01};
        st_d = ST_DONE;
      end
      ST_DONE: begin
        st_d = ST_IDLE;
        rsp_d = '0;
        rsp_d.valid = 1'b1;
        rsp_d.length = len_q;
        case (mode_q)
          amd_pkg::AM_IMMEDIATE: begin
            rsp_d.operand = b1_q;
            rsp_d.has_operand = 1'b1;
          end
          amd_pkg::AM_DIR_SHORT, amd_pkg::AM_BIT_DIR: rsp_d.addr = {8'h00, b1_q};
          amd_pkg::AM_DIR_LONG: rsp_d.addr = {b1_q, rd_data_i};
          amd_pkg::AM_IDX_SHORT: rsp_d.addr = idx_add({8'h00, b1_q}, idx);
          amd_pkg::AM_IDX_LONG: rsp_d.addr = idx_add({b1_q, rd_data_i}, idx);
          amd_pkg::AM_IND_SHORT, amd_pkg::AM_BIT_IND: rsp_d.addr = {8'h00, rd_data_i};
          amd_pkg::AM_INDIDX_SHORT:
            rsp_d.addr = idx_add({8'h00, rd_data_i}, idx);
          amd_pkg::AM_IND_LONG: rsp_d.addr = ptr16;
          amd_pkg::AM_INDIDX_LONG: rsp_d.addr = idx_add(ptr16, idx);
          amd_pkg::AM_REL_DIR: rsp_d.addr = rel_add(fpc_q, b1_q);
          amd_pkg::AM_REL_IND: rsp_d.addr = rel_add(fpc_q, rd_data_i);
          amd_pkg::AM_BIT_DIR_REL: begin
            rsp_d.addr = {8'h00, b1_q};
            rsp_d.operand = rd_data_i;
            rsp_d.has_operand = 1'b1;
          end
          amd_pkg::AM_BIT_IND_REL: begin
            rsp_d.addr = {8'h00, b2_q};
            rsp_d.operand = rd_data_i;
            rsp_d.has_operand = 1'b1;
          end
          default: rsp_d.addr = 16'h0000;
        endcase
        // Read-modify-write forms must stay in page zero
        if (rmw_q && rsp_d.addr > amd_pkg::PAGE0_MAX) begin
          rsp_d.page0_err = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      mode_q <= amd_pkg::AM_INHERENT;
      use_y_q <= 1'b0;
      rmw_q <= 1'b0;
      fpc_q <= 16'h0000;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      p1_q <= 8'h00;
      len_q <= 3'h0;
      rsp_q <= '0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      use_y_q <= use_y_d;
      rmw_q <= rmw_d;
      fpc_q <= fpc_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      p1_q <= p1_d;
      len_q <= len_d;
      rsp_q <= rsp_d;
    end
  end

  assign busy_o = (st_q != ST_IDLE);
  assign rsp_o = rsp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_inherent_len: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !busy_o && eff_mode == amd_pkg::AM_INHERENT
    |=> rsp_o.valid && rsp_o.length == 3'h1)
    else $error("inherent length wrong");
  a_idx_none_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !busy_o && eff_mode == amd_pkg::AM_IDX_NONE && !eff_y
    |=> rsp_o.addr == {8'h00, $past(x_i)})
    else $error("no-offset index address wrong");
  a_short_idx_rng: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && mode_q == amd_pkg::AM_IDX_SHORT |-> rsp_o.addr <= amd_pkg::SHORT_IDX_MAX)
    else $error("short indexed out of range");
  a_short_dir_rng: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && mode_q == amd_pkg::AM_DIR_SHORT |-> rsp_o.addr <= amd_pkg::PAGE0_MAX)
    else $error("short direct out of page zero");
  a_ptr_page0: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_rd_o && (st_q == ST_P1 || st_q == ST_P2 ||
    (st_q == ST_B2 && mode_q == amd_pkg::AM_BIT_IND_REL)) |-> mem_addr_o[15:8] == 8'h00)
    else $error("pointer read outside page zero");
  a_long_len: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && mode_q == amd_pkg::AM_DIR_LONG |-> rsp_o.length == 3'h3)
    else $error("long direct length wrong");
  a_imm_operand: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && mode_q == amd_pkg::AM_IMMEDIATE
    |-> rsp_o.has_operand && rsp_o.length == 3'h2)
    else $error("immediate operand missing");
  a_done_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !busy_o |-> ##[1:5] rsp_o.valid)
    else $error("decode did not finish");
  a_rmw_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && rmw_q && rsp_o.addr > amd_pkg::PAGE0_MAX |-> rsp_o.page0_err)
    else $error("page zero violation not flagged");
  a_mode_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    int'(mode_q) < amd_pkg::NUM_MODES)
    else $error("mode code out of range");
  a_bitrel_len: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && mode_q == amd_pkg::AM_BIT_IND_REL
    |-> rsp_o.length == 3'h3 && rsp_o.has_operand && rsp_o.addr <= amd_pkg::PAGE0_MAX)
    else $error("indirect bit relative result wrong");
  a_ind_long_len: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.valid && mode_q == amd_pkg::AM_IND_LONG |-> rsp_o.length == 3'h2)
    else $error("long indirect length wrong");
  c_indirect_long: cover property (@(posedge clk_i) st_q == ST_P2);
  c_rel: cover property (@(posedge clk_i) rsp_o.valid && mode_q == amd_pkg::AM_REL_DIR);
  c_prefix_y: cover property (@(posedge clk_i) start_i && prefix_i == amd_pkg::PFX_Y);
  c_bit_ind_rel: cover property (@(posedge clk_i) st_q == ST_B3);
  c_rmw_err: cover property (@(posedge clk_i) rsp_o.valid && rsp_o.page0_err);
endmodule
`default_nettype wire

/* amd_pkg.sv */
// What this block does
// - Seventeen operand addressing modes in seven groups are decoded.
// - Inherent instructions are one byte; no operand bytes fetched.
// - Immediate instructions are two bytes; second byte is the operand.
// - Short direct fetches one address byte; range 00 to FF.
// - Long direct fetches a two-byte address; full 64 Kbyte space.
// - Indexed address is unsigned sum of X or Y and offset.
// - Indexed without offset fetches nothing; address is index alone.
// - Short indexed fetches one offset byte; nine-bit sum to 1FE.
// - Long indexed fetches two offset bytes, adds index, full space.
// - Short indirect reads a byte pointer from page zero, range 00-FF.
// - Long indirect forms read a two-byte pointer from page zero.
// - Short indirect indexed adds index to byte pointer, up to 1FE.
// - Relative targets span PC-128 to PC+127, PC after the branch.
// - Read-modify-write memory forms are restricted to page zero; outside it the address is still returned, with page0_err set.
// - Prefixes 90, 92, 91 select Y, indirect, and indirect-with-Y.
// - Relative target adds an eight-bit two's-complement offset to PC.
//
// Purpose: Shared types and constants for the addressing-mode decoder.
// Assumes: 8-bit core with 16-bit address space.
// Notes: Mode codes are an enum; the core's opcode map chooses the mode.
`default_nettype none
package amd_pkg;
  localparam logic [7:0] PFX_Y = 8'h90;
  localparam logic [7:0] PFX_IND = 8'h92;
  localparam logic [7:0] PFX_IND_Y = 8'h91;
  localparam logic [15:0] PAGE0_MAX = 16'h00ff;
  localparam logic [15:0] SHORT_IDX_MAX = 16'h01fe;
  localparam int NUM_MODES = 17;

  typedef enum logic [4:0] {
    AM_INHERENT, AM_IMMEDIATE, AM_DIR_SHORT, AM_DIR_LONG,
    AM_IDX_NONE, AM_IDX_SHORT, AM_IDX_LONG,
    AM_IND_SHORT, AM_IND_LONG, AM_INDIDX_SHORT, AM_INDIDX_LONG,
    AM_REL_DIR, AM_REL_IND, AM_BIT_DIR, AM_BIT_IND,
    AM_BIT_DIR_REL, AM_BIT_IND_REL
  } amd_mode_t;

  typedef struct packed {
    logic valid;
    amd_mode_t mode;
    logic use_y;
    logic rmw;
    logic [7:0] opcode;
  } amd_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] operand;
    logic has_operand;
    logic [2:0] length;
    logic page0_err;
  } amd_rsp_t;
endpackage
`default_nettype wire

/* amd_tb.sv */
// Purpose: Self-checking bench for the addressing-mode decoder.
// Assumes: Byte memory answers in the cycle after each read strobe.
// Notes: Table rows first, then refusal and mid-run reset cases.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    amd_pkg::amd_mode_t mode;
    logic [7:0] pfx;
    logic rmw;
    logic [47:0] d;
    logic [15:0] addr;
    logic [2:0] len;
  } amd_row_t;
  logic clk_i, rst_i, start_i, rmw_i, busy_o, mem_rd_o, rd_pend;
  logic [7:0] opcode_i, prefix_i, x_i, y_i, rd_data_i;
  logic [15:0] pc_i, mem_addr_o, rd_addr;
  amd_pkg::amd_mode_t base_mode_i;
  amd_pkg::amd_rsp_t rsp_o;
  logic [7:0] mem [0:65535];
  amd_row_t rows [22];
  int bad_count, cmp_count;

  amd_decoder amd_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
    .opcode_i(opcode_i), .prefix_i(prefix_i), .base_mode_i(base_mode_i), .rmw_i(rmw_i),
    .pc_i(pc_i), .x_i(x_i), .y_i(y_i), .rd_data_i(rd_data_i), .busy_o(busy_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .rsp_o(rsp_o));

  // ------------------------------------------------------------
  // Clock and memory
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    rd_pend <= mem_rd_o;
    rd_addr <= mem_addr_o;
  end
  // Idle bus shows inverted data so a stale byte never passes
  always @(negedge clk_i) begin
    if (rst_i) begin
      rd_data_i <= 8'h00;
    end else begin
      rd_data_i <= rd_pend ? mem[rd_addr] : ~rd_data_i;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic go(input amd_row_t r);
    mem[16'h1001] = r.d[47:40];
    mem[16'h1002] = r.d[39:32];
    mem[{8'h00, r.d[47:40]}] = r.d[31:24];
    mem[{8'h00, r.d[47:40] + 8'h01}] = r.d[23:16];
    x_i = r.d[15:8];
    y_i = r.d[7:0];
    base_mode_i = r.mode;
    prefix_i = r.pfx;
    rmw_i = r.rmw;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
  endtask
  task automatic wait_valid();
    int n;
    n = 0;
    while (rsp_o.valid !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 10) begin
      check(16'h0, 16'h1);
      conclude();
    end
  endtask
  task automatic run(input amd_row_t r);
    logic imm;
    imm = (r.mode == amd_pkg::AM_IMMEDIATE);
    go(r);
    wait_valid();
    check({13'h0, rsp_o.length}, {13'h0, r.len});
    if (!imm && r.mode != amd_pkg::AM_INHERENT) begin
      check(rsp_o.addr, r.addr);
    end
    if (imm) begin
      check({7'h0, rsp_o.has_operand, rsp_o.operand}, {8'h01, r.d[47:40]});
    end
    if (r.mode == amd_pkg::AM_BIT_DIR_REL) begin
      check({8'h0, rsp_o.operand}, {8'h0, r.d[39:32]});
    end
    check({15'h0, rsp_o.page0_err}, {15'h0, r.rmw & (r.addr > 16'h00ff)});
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    rmw_i = 1'b0;
    opcode_i = 8'h3c;
    prefix_i = 8'h00;
    x_i = 8'h00;
    y_i = 8'h00;
    pc_i = 16'h1000;
    base_mode_i = amd_pkg::AM_INHERENT;
    bad_count = 0;
    cmp_count = 0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
    end
    rows[0] = '{amd_pkg::AM_INHERENT, 8'h00, 1'b0, 48'h0, 16'h0, 3'h1};
    rows[1] = '{amd_pkg::AM_IMMEDIATE, 8'h00, 1'b0, 48'hc3_00_00_00_00_00, 16'h0, 3'h2};
    rows[2] = '{amd_pkg::AM_DIR_SHORT, 8'h00, 1'b1, 48'hff_00_00_00_00_00, 16'h00ff, 3'h2};
    rows[3] = '{amd_pkg::AM_DIR_LONG, 8'h00, 1'b1, 48'hab_cd_00_00_00_00, 16'habcd, 3'h3};
    rows[4] = '{amd_pkg::AM_IDX_NONE, 8'h00, 1'b0, 48'h00_00_00_00_7e_00, 16'h007e, 3'h1};
    rows[5] = '{amd_pkg::AM_IDX_NONE, 8'h90, 1'b0, 48'h00_00_00_00_00_81, 16'h0081, 3'h1};
    rows[6] = '{amd_pkg::AM_IDX_SHORT, 8'h00, 1'b1, 48'hff_00_00_00_ff_00, 16'h01fe, 3'h2};
    rows[7] = '{amd_pkg::AM_IDX_LONG, 8'h00, 1'b0, 48'hff_ff_00_00_02_00, 16'h0001, 3'h3};
    rows[8] = '{amd_pkg::AM_IDX_LONG, 8'h90, 1'b0, 48'h12_34_00_00_00_10, 16'h1244, 3'h3};
    rows[9] = '{amd_pkg::AM_DIR_SHORT, 8'h92, 1'b0, 48'h40_00_9a_00_00_00, 16'h009a, 3'h2};
    rows[10] = '{amd_pkg::AM_DIR_LONG, 8'h92, 1'b0, 48'hff_00_be_ef_00_00, 16'hbeef, 3'h2};
    rows[11] = '{amd_pkg::AM_IDX_SHORT, 8'h92, 1'b0, 48'h20_00_f0_00_20_00, 16'h0110, 3'h2};
    rows[12] = '{amd_pkg::AM_IDX_SHORT, 8'h91, 1'b0, 48'h20_00_ff_00_00_ff, 16'h01fe, 3'h2};
    rows[13] = '{amd_pkg::AM_IDX_LONG, 8'h92, 1'b0, 48'h30_00_ff_f0_20_00, 16'h0010, 3'h2};
    rows[14] = '{amd_pkg::AM_IDX_LONG, 8'h91, 1'b0, 48'h30_00_12_00_00_34, 16'h1234, 3'h2};
    rows[15] = '{amd_pkg::AM_REL_DIR, 8'h00, 1'b0, 48'h80_00_00_00_00_00, 16'h0f82, 3'h2};
    rows[16] = '{amd_pkg::AM_REL_DIR, 8'h00, 1'b0, 48'h7f_00_00_00_00_00, 16'h1081, 3'h2};
    rows[17] = '{amd_pkg::AM_REL_DIR, 8'h92, 1'b0, 48'h50_00_fe_00_00_00, 16'h1000, 3'h2};
    rows[18] = '{amd_pkg::AM_BIT_DIR, 8'h00, 1'b0, 48'h10_00_00_00_00_00, 16'h0010, 3'h2};
    rows[19] = '{amd_pkg::AM_BIT_DIR, 8'h92, 1'b0, 48'h10_00_77_00_00_00, 16'h0077, 3'h2};
    rows[20] = '{amd_pkg::AM_BIT_DIR_REL, 8'h00, 1'b0, 48'h10_f6_00_00_00_00, 16'h0010, 3'h3};
    rows[21] = '{amd_pkg::AM_BIT_DIR_REL, 8'h92, 1'b0, 48'h10_f6_55_00_00_00, 16'h0055, 3'h3};
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    check({14'h0, busy_o, rsp_o.valid}, 16'h0);
    @(negedge clk_i);
    for (int i = 0; i < 22; i++) begin
      run(rows[i]);
    end
    // Second start while busy must be dropped
    go(rows[3]);
    check({15'h0, busy_o}, 16'h1);
    base_mode_i = amd_pkg::AM_IMMEDIATE;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    wait_valid();
    check(rsp_o.addr, 16'habcd);
    repeat (6) begin
      @(negedge clk_i);
      check({15'h0, rsp_o.valid}, 16'h0);
    end
    // Reset in mid-fetch returns to idle, then a fresh decode works
    go(rows[10]);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    check({14'h0, busy_o, rsp_o.valid}, 16'h0);
    @(negedge clk_i);
    run(rows[10]);
    conclude();
  end
endmodule
`default_nettype wire
